// ---- bsq_burst_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Fixed-count burst emits exactly N carrier cycles.
// - Gated burst passes carrier only while gate valid.
// - Internal source starts trains from internal timer.
// - External trigger edge launches counter_in bursts (one if zero).
// - External gate uses input level, not edges.
// - Each manual activation while idle launches counter_in bursts (one if zero).
// - Every fixed-count burst starts at configured start phase; gated bursts get no phase load.
// - Trains spaced by burst period, start to start.
// - Cycle count only applies in fixed-count type.
// - Infinite count keeps carrier running after trigger.
// - External/manual: counter trains per trigger.
// - Positive polarity gate high, negative gate low.
// - Trigger delay precedes first carrier cycle.
// - Trigger output rising, falling or off selectable.
// - External trigger edge rising or falling selectable.
// - After burst, hold start, end or middle value.
// - Rising trigger output marks each internal or manual burst start.
module bsq_burst_sequencer
  import bsq_pkg::*;
#(
  parameter int CW = BSQ_CW,
  parameter int NW = BSQ_NW
) (
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              enable_in,
  input  wire logic              gated_mode_in,
  input  wire bsq_pkg::bsq_src_e source_in,
  input  wire logic              ext_sig_in,
  input  wire logic              manual_trig_in,
  input  wire logic              gate_pos_in,
  input  wire logic              ext_rise_in,
  input  wire logic [CW-1:0]     period_cyc_in,
  input  wire logic [CW-1:0]     delay_cyc_in,
  input  wire logic [NW-1:0]     cycles_in,
  input  wire logic              cycles_inf_in,
  input  wire logic [NW-1:0]     counter_in,
  input  wire logic              carrier_wrap_in,
  input  wire logic [BSQ_PW-1:0] start_phase_in,
  input  wire bsq_pkg::bsq_tout_e tout_mode_in,
  input  wire bsq_pkg::bsq_hold_e hold_sel_in,
  output var  logic              carrier_en_out,
  output var  logic              phase_load_out,
  output var  logic [BSQ_PW-1:0] phase_out,
  output var  logic [1:0]        hold_sel_out,
  output var  logic              trig_out,
  output var  logic              busy_out
);
  import bsq_pkg::*;

  // -----------------------------------------------------------------------
  // Trigger qualification
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BSQ_IDLE,
    BSQ_DELAY,
    BSQ_RUN,
    BSQ_WAIT,
    BSQ_GATE
  } bsq_state_e;

  bsq_state_e state;
  bsq_state_e next_state;
  logic       ext_prev;
  logic       man_prev;
  logic       ext_edge;
  logic       man_edge;
  logic       ext_level;
  logic       gate_open;
  logic       trig_evt;

  // Edge selection on the external input; manual press on its rising edge.
  assign ext_edge  = ext_rise_in ? (ext_sig_in && !ext_prev)
                                 : (!ext_sig_in && ext_prev);
  assign man_edge  = manual_trig_in && !man_prev;
  assign ext_level = ext_sig_in;
  assign gate_open = gate_pos_in ? ext_level : !ext_level;

  // Events while busy are dropped because only IDLE looks at them.
  always_comb begin
    trig_evt = 1'b0;
    case (source_in)
      BSQ_SRC_EXT: trig_evt = ext_edge;
      BSQ_SRC_MAN: trig_evt = man_edge;
      default:     trig_evt = 1'b1;
    endcase
  end

  // -----------------------------------------------------------------------
  // Counters
  // -----------------------------------------------------------------------
  logic [CW-1:0] delay_cnt;
  logic [CW-1:0] next_delay_cnt;
  logic [CW-1:0] per_cnt;
  logic [CW-1:0] next_per_cnt;
  logic [NW-1:0] train_cnt;
  logic [NW-1:0] next_train_cnt;
  logic          cyc_load;
  logic          cyc_last;
  logic          cyc_dec;
  logic          train_start;
  logic          next_carrier_en;
  logic          next_trig;
  logic          trig_level;
  logic          next_trig_level;
  logic [CW-1:0] delay_eff;
  logic [NW-1:0] trains_eff;

  // Delay is never shorter than the hardware latency.
  assign delay_eff = (delay_cyc_in < CW'(MIN_DELAY_CYC))
                   ? CW'(MIN_DELAY_CYC) : delay_cyc_in;
  // The internal source runs one train per timer tick.
  assign trains_eff = (source_in == BSQ_SRC_INT || counter_in == '0)
                    ? NW'(1) : counter_in;

  // Carrier cycle counter, reloaded at every train start outside gated type.
  bsq_down_counter #(
    .W(NW)
  ) u_cycles (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .load_in  (cyc_load),
    .value_in (cycles_in),
    .dec_in   (cyc_dec),
    .last_out (cyc_last)
  );

  assign cyc_dec = (state == BSQ_RUN) && carrier_wrap_in;

  // -----------------------------------------------------------------------
  // Sequencer next state
  // -----------------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_delay_cnt  = delay_cnt;
    next_per_cnt    = (per_cnt != '0) ? per_cnt - CW'(1) : per_cnt;
    next_train_cnt  = train_cnt;
    next_carrier_en = carrier_en_out;
    train_start     = 1'b0;
    if (!enable_in) begin
      next_state      = BSQ_IDLE;
      next_carrier_en = 1'b0;
    end else begin
      case (state)
        BSQ_IDLE: begin
          next_carrier_en = 1'b0;
          if (gated_mode_in && source_in == BSQ_SRC_EXT) begin
            next_state = BSQ_GATE;
          end else if (trig_evt) begin
            next_state     = BSQ_DELAY;
            next_delay_cnt = delay_eff;
            next_train_cnt = trains_eff;
          end
        end
        BSQ_DELAY: begin
          next_delay_cnt = delay_cnt - CW'(1);
          if (delay_cnt <= CW'(1)) begin
            train_start = 1'b1;
          end
        end
        BSQ_RUN: begin
          // Stop only on a whole carrier cycle boundary.
          if (carrier_wrap_in && cyc_last && !cycles_inf_in) begin
            next_carrier_en = 1'b0;
            if (source_in == BSQ_SRC_INT) begin
              // The timer never stops, so the next train waits a period.
              next_state = BSQ_WAIT;
            end else begin
              next_state     = (train_cnt <= NW'(1)) ? BSQ_IDLE : BSQ_WAIT;
              next_train_cnt = train_cnt - NW'(1);
            end
          end
          if (per_cnt <= CW'(1) && cycles_inf_in == 1'b0
              && (train_cnt > NW'(1) || source_in == BSQ_SRC_INT)
              && !next_carrier_en) begin
            train_start = 1'b1;
          end
        end
        BSQ_WAIT: begin
          if (per_cnt <= CW'(1)) begin
            train_start = 1'b1;
          end
        end
        BSQ_GATE: begin
          next_carrier_en = gate_open;
          if (!(gated_mode_in && source_in == BSQ_SRC_EXT)) begin
            next_state      = BSQ_IDLE;
            next_carrier_en = 1'b0;
          end
        end
        default: begin
          next_state = BSQ_IDLE;
        end
      endcase
      if (train_start) begin
        next_state      = BSQ_RUN;
        next_carrier_en = 1'b1;
        next_per_cnt    = period_cyc_in;
      end
    end
  end

  // Cycle count is only loaded outside gated type.
  assign cyc_load = train_start && !gated_mode_in;

  // Trigger output: a level high for half the period from each train start.
  always_comb begin
    next_trig_level = trig_level;
    if (train_start) begin
      next_trig_level = 1'b1;
    end else if (per_cnt <= (period_cyc_in >> 1)) begin
      next_trig_level = 1'b0;
    end
    case (tout_mode_in)
      BSQ_TOUT_UP:   next_trig = next_trig_level;
      BSQ_TOUT_DOWN: next_trig = !next_trig_level;
      default:       next_trig = 1'b0;
    endcase
    if (source_in == BSQ_SRC_EXT) begin
      next_trig = 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // State registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state          <= BSQ_IDLE;
      delay_cnt      <= BSQ_ZERO[CW-1:0];
      per_cnt        <= BSQ_ZERO[CW-1:0];
      train_cnt      <= '0;
      carrier_en_out <= 1'b0;
      phase_load_out <= 1'b0;
      phase_out      <= '0;
      hold_sel_out   <= 2'h0;
      trig_out       <= 1'b0;
      trig_level     <= 1'b0;
      ext_prev       <= 1'b0;
      man_prev       <= 1'b0;
    end else begin
      state          <= next_state;
      delay_cnt      <= next_delay_cnt;
      per_cnt        <= next_per_cnt;
      train_cnt      <= next_train_cnt;
      carrier_en_out <= next_carrier_en;
      phase_load_out <= train_start;
      phase_out      <= start_phase_in;
      hold_sel_out   <= hold_sel_in;
      trig_out       <= next_trig;
      trig_level     <= next_trig_level;
      ext_prev       <= ext_sig_in;
      man_prev       <= manual_trig_in;
    end
  end

  // Busy covers delay, every train and the gaps between them, but not the gated state.
  assign busy_out = (state != BSQ_IDLE) && (state != BSQ_GATE);

endmodule : bsq_burst_sequencer

`default_nettype wire

// ---- bsq_pkg.sv ----
package bsq_pkg;

  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSQ_SRC_INT,
    BSQ_SRC_EXT,
    BSQ_SRC_MAN
  } bsq_src_e;

  typedef enum logic [1:0] {
    BSQ_TOUT_OFF,
    BSQ_TOUT_UP,
    BSQ_TOUT_DOWN
  } bsq_tout_e;

  typedef enum logic [1:0] {
    BSQ_HOLD_START,
    BSQ_HOLD_END,
    BSQ_HOLD_MID
  } bsq_hold_e;

  // ---------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------
  localparam int BSQ_CW         = 32;
  localparam int BSQ_NW         = 16;
  localparam int BSQ_PW         = 16;
  localparam int CLK_PERIOD_NS  = 10;
  // Minimum trigger delay: the hardware latency, one clock.
  localparam int MIN_DELAY_NS   = 10;
  localparam int MIN_DELAY_CYC  =
    (MIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [BSQ_CW-1:0] BSQ_ONE  = 32'h0000_0001;
  localparam logic [BSQ_CW-1:0] BSQ_ZERO = 32'h0000_0000;

endpackage : bsq_pkg

// ---- bsq_down_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

// Loadable down counter that flags when it has reached one.
module bsq_down_counter #(
  parameter int W = 32
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         dec_in,
  output var  logic         last_out
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Load wins over decrement; the counter rests at zero.
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = value_in;
    end else if (dec_in && count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign last_out = (count <= W'(1));

endmodule : bsq_down_counter

`default_nettype wire

// ---- bsq_sig_src.sv ----
`timescale 1ns/1ps
`default_nettype none

// External trigger or gate source, synchronous to the instrument clock.
module bsq_sig_src (
  input  wire logic clk_in,
  output var  logic sig_out
);
  // The line rests low until a test sets a level.
  initial sig_out = 1'b0;

  // Each call moves the line once, just after an edge, and keeps it there.
  task automatic level(input logic lvl);
    @(posedge clk_in);
    #1 sig_out = lvl;
  endtask : level
endmodule : bsq_sig_src

`default_nettype wire

// ---- bsq_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

// Port checks; slack of one or two edges allows for the registered outputs.
module bsq_chk
  import bsq_pkg::*;
(
  input wire logic               clk_in,
  input wire logic               rstn_in,
  input wire logic               enable_in,
  input wire logic               gated_mode_in,
  input wire bsq_pkg::bsq_src_e  source_in,
  input wire logic               ext_sig_in,
  input wire logic               gate_pos_in,
  input wire logic               carrier_wrap_in,
  input wire logic               cycles_inf_in,
  input wire logic [BSQ_PW-1:0]  start_phase_in,
  input wire bsq_pkg::bsq_tout_e tout_mode_in,
  input wire logic               carrier_en_out,
  input wire logic               phase_load_out,
  input wire logic [BSQ_PW-1:0]  phase_out,
  input wire logic               trig_out,
  input wire logic               busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Gate qualifiers.
  wire gt = enable_in && gated_mode_in && source_in == BSQ_SRC_EXT;
  wire gm = ext_sig_in == gate_pos_in;

  a_gate_pass: assert property (
    (gt && gm) [*3] |-> carrier_en_out)
    else $error("carrier off while gate open");
  a_gate_block: assert property (
    (gt && !gm) [*3] |-> !carrier_en_out)
    else $error("carrier on while gate shut");
  a_load_first: assert property (
    phase_load_out |-> carrier_en_out && !$past(carrier_en_out))
    else $error("phase load not at carrier start");
  a_load_phase: assert property (
    phase_load_out |-> phase_out == $past(start_phase_in))
    else $error("wrong start phase");
  a_rise_load: assert property (
    $rose(carrier_en_out) && !gated_mode_in |-> phase_load_out)
    else $error("burst began without phase load");
  a_end_wrap: assert property (
    $fell(carrier_en_out) && !gated_mode_in && $past(enable_in)
    && !$past(cycles_inf_in) |-> $past(carrier_wrap_in))
    else $error("burst ended off a carrier cycle end");
  a_busy_burst: assert property (
    carrier_en_out && !gated_mode_in |-> busy_out)
    else $error("burst running while idle");
  a_inf_holds: assert property (
    carrier_en_out && cycles_inf_in && enable_in && !gated_mode_in
    |=> carrier_en_out)
    else $error("infinite burst stopped");
  a_trig_quiet: assert property (
    (source_in == BSQ_SRC_EXT || tout_mode_in == BSQ_TOUT_OFF) [*2]
    |-> !trig_out)
    else $error("trigger output active while off");
  a_trig_start: assert property (
    $rose(carrier_en_out) && source_in == BSQ_SRC_INT
    && tout_mode_in == BSQ_TOUT_UP |-> $rose(trig_out))
    else $error("trigger output not at burst start");
endmodule : bsq_chk

bind bsq_burst_sequencer bsq_chk u_chk (.clk_in, .rstn_in, .enable_in,
  .gated_mode_in, .source_in, .ext_sig_in, .gate_pos_in, .carrier_wrap_in,
  .cycles_inf_in, .start_phase_in, .tout_mode_in, .carrier_en_out,
  .phase_load_out, .phase_out, .trig_out, .busy_out);

`default_nettype wire

// ---- test_burst_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_burst_sequencer;
  import bsq_pkg::*;
  logic clk_in, rstn_in, enable_in, gated_mode_in, ext_sig_in, busy_out;
  logic manual_trig_in, gate_pos_in, ext_rise_in, cycles_inf_in, en_q;
  logic carrier_wrap_in, carrier_en_out, phase_load_out, trig_out, tr_q;
  bsq_src_e source_in;
  bsq_tout_e tout_mode_in;
  bsq_hold_e hold_sel_in;
  logic [1:0] hold_sel_out;
  logic [BSQ_CW-1:0] period_cyc_in, delay_cyc_in;
  logic [BSQ_NW-1:0] cycles_in, counter_in;
  logic [BSQ_PW-1:0] start_phase_in, phase_out;
  int failures, check_count, cyc, wcnt, t0, n, d;
  int rises[$], wraps[$], trigs[$], falls[$];

  bsq_burst_sequencer dut (.clk_in, .rstn_in, .enable_in, .gated_mode_in,
    .source_in, .ext_sig_in, .manual_trig_in, .gate_pos_in, .ext_rise_in,
    .period_cyc_in, .delay_cyc_in, .cycles_in, .cycles_inf_in, .counter_in,
    .carrier_wrap_in, .start_phase_in, .tout_mode_in, .hold_sel_in,
    .carrier_en_out, .phase_load_out, .phase_out, .hold_sel_out, .trig_out,
    .busy_out);
  bsq_sig_src src (.clk_in, .sig_out(ext_sig_in));

  always #5 clk_in = !clk_in;

  // Carrier stand-in (one wrap every four enabled cycles) and the model's
  // record of burst starts, cycles per burst and trigger output edges.
  always @(posedge clk_in) begin
    cyc++;
    if (carrier_en_out && !en_q) begin
      rises.push_back(cyc);
      wraps.push_back(0);
    end
    if (carrier_wrap_in && carrier_en_out && wraps.size() > 0)
      wraps[wraps.size()-1]++;
    if (trig_out && !tr_q) trigs.push_back(cyc);
    if (!trig_out && tr_q) falls.push_back(cyc);
    if (phase_load_out) check("phase", start_phase_in, phase_out);
    en_q = carrier_en_out;
    tr_q = trig_out;
    wcnt = carrier_en_out ? (wcnt + 1) % 4 : 0;
    carrier_wrap_in <= #1 (wcnt == 3);
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    check_count++;
    if (exp !== got) begin
      failures++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : tick

  // This task loads settings with the function off, so no burst starts on a mix of old and new ones.
  task automatic cfg(input bsq_src_e s, input int per, nc, cnt, dl);
    enable_in = 0;
    tick(3);
    gated_mode_in = 0;
    cycles_inf_in = 0;
    source_in = s;
    period_cyc_in = per;
    cycles_in = BSQ_NW'(nc);
    counter_in = BSQ_NW'(cnt);
    delay_cyc_in = dl;
    rises.delete();
    wraps.delete();
    trigs.delete();
    falls.delete();
    enable_in = 1;
  endtask : cfg

  task automatic bursts(input int cnt, per, nc);
    for (int i = 0; i < cnt && i < rises.size(); i++) begin
      check("cycles", nc, wraps[i]);
      if (i > 0) check("spacing", per, rises[i] - rises[i-1]);
    end
  endtask : bursts

  task automatic press();
    manual_trig_in = 1;
    tick(1);
    manual_trig_in = 0;
  endtask : press

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // A hang is cut short well beyond the run's length of under 8 us.
  initial begin
    #60us;
    failures++;
    stop_test();
  end

  initial begin
    {clk_in, rstn_in, enable_in, gated_mode_in, manual_trig_in} = '0;
    {gate_pos_in, ext_rise_in, cycles_inf_in, carrier_wrap_in} = '0;
    {en_q, tr_q, failures, check_count, cyc, wcnt} = '0;
    {period_cyc_in, delay_cyc_in, cycles_in, counter_in} = '0;
    source_in = BSQ_SRC_INT;
    tout_mode_in = BSQ_TOUT_UP;
    hold_sel_in = BSQ_HOLD_START;
    void'($urandom(64849));
    start_phase_in = BSQ_PW'($urandom);
    tick(6);
    rstn_in = 1;
    cfg(BSQ_SRC_INT, 40, 3, 1, 1);
    tick(170);
    check("starts", 1, rises.size() >= 3);
    bursts(rises.size() - 1, 40, 3);
    check("trig count", rises.size(), trigs.size());
    check("trig align", rises[0], trigs[0]);
    $display("test internal done");
    for (int e = 0; e < 2; e++) begin
      src.level(e[0]);
      ext_rise_in = e[0];
      n = $urandom_range(3, 1);
      d = $urandom_range(6, 1);
      cfg(BSQ_SRC_EXT, 30, 2, n, d);
      tick(3);
      src.level(!e[0]);
      tick(d + 10);
      check("wrong edge", 0, rises.size());
      src.level(e[0]);
      t0 = cyc;
      tick(d + 5);
      src.level(!e[0]);
      src.level(e[0]);
      tick(30 * n + 20);
      check("ext bursts", n, rises.size());
      bursts(n, 30, 2);
      // Edge seen one clock after it lands, then d clocks of delay, and
      // the record lags the registered enable by one more edge.
      check("delay", d + 2, rises[0] - t0);
    end
    $display("test external done");
    cfg(BSQ_SRC_MAN, 25, 1, 2, 1);
    tout_mode_in = BSQ_TOUT_OFF;
    press();
    tick(70);
    check("man bursts", 2, rises.size());
    bursts(2, 25, 1);
    check("trig off", 0, trigs.size());
    check("idle", 0, busy_out);
    $display("test manual done");
    cfg(BSQ_SRC_EXT, 25, 1, 1, 1);
    gated_mode_in = 1;
    for (int i = 0; i < 4; i++) begin
      gate_pos_in = i[1];
      src.level(i[0]);
      tick(4);
      check("gate", i[0] == i[1], carrier_en_out);
    end
    $display("test gated done");
    cfg(BSQ_SRC_MAN, 25, 1, 1, 1);
    cycles_inf_in = 1;
    tout_mode_in = BSQ_TOUT_DOWN;
    press();
    tick(200);
    check("infinite", 1, carrier_en_out);
    check("busy", 1, busy_out);
    check("trig fall", rises[0], falls[0]);
    check("inf starts", 1, rises.size());
    for (int h = 0; h < 3; h++) begin
      hold_sel_in = bsq_hold_e'(h);
      tick(2);
      check("hold", h, hold_sel_out);
    end
    enable_in = 0;
    tick(2);
    check("stopped", 0, carrier_en_out);
    $display("test infinite and hold done");
    stop_test();
  end
endmodule : test_burst_sequencer

`default_nettype wire
